// ---- src/ufcc_pkg.sv ----
// ****************************************************************
// register map and field layout
// ****************************************************************
package ufcc_pkg;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_LINE_CONTROL = 8'h00;
	localparam logic [7:0] OFS_FRAME_CLOCK = 8'h04;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h0C;

	// line control register fields
	localparam int LC_BREAK_SEND_BIT = 0;
	localparam int LC_MUTE_BIT = 1;
	localparam int LC_RX_ON_BIT = 2;
	localparam int LC_WAKE_ADDR_BIT = 3;
	localparam int LC_SYNC_MODE_BIT = 4;
	localparam int LC_SMARTCARD_BIT = 5;
	localparam logic [31:0] LC_WRITE_MASK = 32'h0000003F;

	// frame and clock control register fields
	localparam int FC_NODE_ADDR_LSB = 0;
	localparam int FC_NODE_ADDR_W = 4;
	localparam int FC_BREAK_LEN_BIT = 5;
	localparam int FC_BREAK_IRQ_BIT = 6;
	localparam int FC_LAST_PULSE_BIT = 8;
	localparam int FC_CAPTURE_EDGE_BIT = 9;
	localparam int FC_IDLE_LEVEL_BIT = 10;
	localparam int FC_CLOCK_PIN_BIT = 11;
	localparam int FC_STOP_LSB = 12;
	localparam int FC_LIN_BIT = 14;
	localparam logic [31:0] FC_WRITE_MASK = 32'h00007F6F;

	// event status and mask fields
	localparam int EV_BREAK_DET_BIT = 0;
	localparam int EV_WAKE_BIT = 1;
	localparam int EV_BREAK_SENT_BIT = 2;
	localparam int EV_W = 3;

	// reset values
	localparam logic [31:0] LC_RESET = 32'h00000000;
	localparam logic [31:0] FC_RESET = 32'h00000000;
	localparam logic [2:0] EV_RESET = 3'h0;

	// stop length codes and their length in half bits
	localparam logic [1:0] STOP_ONE = 2'h0;
	localparam logic [1:0] STOP_HALF = 2'h1;
	localparam logic [1:0] STOP_TWO = 2'h2;
	localparam logic [1:0] STOP_ONE_HALF = 2'h3;
	localparam logic [2:0] HALVES_ONE = 3'h2;
	localparam logic [2:0] HALVES_HALF = 3'h1;
	localparam logic [2:0] HALVES_TWO = 3'h4;
	localparam logic [2:0] HALVES_ONE_HALF = 3'h3;

	// break frame lengths in bit times
	localparam int BREAK_SHORT_BITS = 10;
	localparam int BREAK_LONG_BITS = 11;

	// default bit time in system clocks
	localparam int BIT_CYCLES_DEFAULT = 16;

endpackage

// ---- src/ufcc_sclk_gen.sv ----
`timescale 1ns/10ps
// ****************************************************************
// synchronous serial clock generator
// ****************************************************************
module ufcc_sclk_gen #(
	parameter int HALF_CYCLES = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic active_in,
	input wire logic idle_level_in,
	input wire logic capture_edge_in,
	input wire logic last_pulse_in,
	input wire logic bit_start_in,
	input wire logic last_bit_in,
	output logic sclk_out,
	output logic capture_out
);

	typedef struct packed {
		logic running;
		logic toggled;
		logic [15:0] cnt;
		logic sclk;
		logic capture;
	} ufcc_sclk_t;

	localparam logic [15:0] MID = 16'(HALF_CYCLES - 1);
	localparam logic [15:0] LAST = 16'(2 * HALF_CYCLES - 1);

	ufcc_sclk_t s;
	ufcc_sclk_t next_s;

	// two edges per bit, data captured at mid bit on the selected edge
	always_comb begin
		next_s = s;
		next_s.capture = 1'b0;
		if (s.running) begin
			next_s.cnt = s.cnt + 16'h0001;
			if (s.cnt == MID) begin
				next_s.toggled = ~s.toggled; // RULE9
				next_s.capture = 1'b1; // RULE9
				if (capture_edge_in) begin
					next_s.running = 1'b0;
				end
			end else if (s.cnt == LAST) begin
				next_s.toggled = 1'b0;
				next_s.running = 1'b0;
			end
		end
		// the last bit pulse is suppressed unless asked for
		if (bit_start_in && active_in && (!last_bit_in || last_pulse_in)) begin // RULE10
			next_s.running = 1'b1;
			next_s.cnt = 16'h0000;
			next_s.toggled = capture_edge_in; // RULE9
		end
		if (!active_in) begin
			next_s.running = 1'b0;
			next_s.toggled = 1'b0;
		end
		next_s.sclk = idle_level_in ^ next_s.toggled; // RULE8
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
		end else if (ce_in) begin
			s <= next_s;
		end
	end

	assign sclk_out = s.sclk;
	assign capture_out = s.capture;

endmodule // ufcc_sclk_gen

// ---- src/ufcc_top.sv ----
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
// Summary of operation
// RULE1: the receiver is kept off while the receiver enable bit is 0 and runs while it is 1.
// RULE2: software sets and clears the mute bit; idle-line wake clears it after wake up.
// RULE3: address wake clears mute on a matching address and sets it again on a mismatch.
// RULE4: writing 1 to the break request sends a break, cleared by hardware when it ends.
// RULE5: the block is in LIN mode while the LIN enable bit is 1, ordinary mode otherwise.
// RULE6: stop length codes 00, 01, 10, 11 give 1, 0.5, 2 and 1.5 stop bits.
// RULE7: the clock pin is driven only with clock pin enable set in sync or smartcard mode.
// RULE8: the clock rests low when idle for polarity 0 and high for polarity 1.
// RULE9: data are captured on the first clock edge for phase 0, the second for phase 1.
// RULE10: the last data bit clock pulse is output only while the last bit pulse bit is 1; the code also outputs it in smartcard mode with that bit at 0.
// RULE11: a detected break raises the interrupt only while the break interrupt enable is 1.
// RULE12: break length select 0 detects a 10 bit break, 1 detects an 11 bit break.
// RULE13: software keeps polarity, phase and last bit pulse unchanged while sending.
// RULE14: bits 31 to 15 of the frame and clock control register always read zero.
// RULE15: software leaves bit 7 of the frame and clock control register at zero.
// RULE16: a writable four bit node address, reset to zero, is compared in address wake.
// RULE17: a break request stays set until its break has fully been sent; the code also clears it on a line control write with the break bit at 0.

// ****************************************************************
// frame and clock control block
// ****************************************************************
module ufcc_top #(
	parameter int BIT_CYCLES = ufcc_pkg::BIT_CYCLES_DEFAULT
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// register bus
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// receive pin and receiver events
	input wire logic rx_pin_in,
	input wire logic rx_idle_in,
	input wire logic rx_addr_valid_in,
	input wire logic [3:0] rx_addr_in,
	// transmitter handshakes
	input wire logic tx_bit_start_in,
	input wire logic tx_last_bit_in,
	input wire logic tx_break_done_in,
	// control outputs to receiver and transmitter
	output logic rx_on_out,
	output logic rx_mute_out,
	output logic tx_break_req_out,
	output logic lin_mode_out,
	output logic [2:0] stop_halves_out,
	// serial clock pin
	output logic sclk_out,
	output logic sclk_oe_out,
	output logic capture_out,
	// events
	output logic break_det_out,
	output logic irq_out
);

	// ****************************************************************
	// state
	// ****************************************************************

	typedef struct packed {
		// receive pin synchroniser
		logic rx_meta;
		logic rx_line;
		// line control bits
		logic break_send;
		logic mute;
		logic rx_on;
		logic wake_by_addr;
		logic sync_mode;
		logic smartcard;
		// frame and clock control bits
		logic lin_mode;
		logic [1:0] stop_sel;
		logic clock_pin;
		logic idle_level;
		logic capture_edge;
		logic last_pulse;
		logic break_irq;
		logic break_len;
		logic [3:0] node_addr;
		// sticky events and their mask
		logic [2:0] status;
		logic [2:0] mask;
		// break detector, 16 bits cover eleven slow bit times
		logic [15:0] low_cnt;
		logic armed;
		logic break_det;
		// registered outputs
		logic [2:0] stop_halves;
		logic sclk_oe;
		logic [31:0] rdata;
		logic irq;
	} ufcc_state_t;

	// current and next copy of all state
	ufcc_state_t s;
	ufcc_state_t next_s;
	logic sclk_active;

	// ****************************************************************
	// helpers
	// ****************************************************************

	// stop length code to stop period in half bit times
	function automatic logic [2:0] stop_halves(input logic [1:0] sel);
		logic [2:0] h;
		h = ufcc_pkg::HALVES_ONE;
		case (sel)
			ufcc_pkg::STOP_ONE: h = ufcc_pkg::HALVES_ONE;
			ufcc_pkg::STOP_HALF: h = ufcc_pkg::HALVES_HALF;
			ufcc_pkg::STOP_TWO: h = ufcc_pkg::HALVES_TWO;
			ufcc_pkg::STOP_ONE_HALF: h = ufcc_pkg::HALVES_ONE_HALF;
			default: h = ufcc_pkg::HALVES_ONE;
		endcase
		return h;
	endfunction

	// low time in system clocks that makes a break
	function automatic logic [15:0] break_cycles(input logic long_sel);
		logic [15:0] c;
		if (long_sel) begin
			c = 16'(ufcc_pkg::BREAK_LONG_BITS * BIT_CYCLES);
		end else begin
			c = 16'(ufcc_pkg::BREAK_SHORT_BITS * BIT_CYCLES);
		end
		return c;
	endfunction

	// read view of the frame and clock control register
	function automatic logic [31:0] frame_clock_view(input ufcc_state_t v);
		logic [31:0] r;
		r = 32'h00000000; // RULE14
		r[ufcc_pkg::FC_LIN_BIT] = v.lin_mode;
		r[ufcc_pkg::FC_STOP_LSB +: 2] = v.stop_sel;
		r[ufcc_pkg::FC_CLOCK_PIN_BIT] = v.clock_pin;
		r[ufcc_pkg::FC_IDLE_LEVEL_BIT] = v.idle_level;
		r[ufcc_pkg::FC_CAPTURE_EDGE_BIT] = v.capture_edge;
		r[ufcc_pkg::FC_LAST_PULSE_BIT] = v.last_pulse;
		r[ufcc_pkg::FC_BREAK_IRQ_BIT] = v.break_irq;
		r[ufcc_pkg::FC_BREAK_LEN_BIT] = v.break_len;
		r[ufcc_pkg::FC_NODE_ADDR_LSB +: ufcc_pkg::FC_NODE_ADDR_W] = v.node_addr;
		return r;
	endfunction

	// read view of the line control register
	function automatic logic [31:0] line_control_view(input ufcc_state_t v);
		logic [31:0] r;
		r = 32'h00000000;
		r[ufcc_pkg::LC_BREAK_SEND_BIT] = v.break_send;
		r[ufcc_pkg::LC_MUTE_BIT] = v.mute;
		r[ufcc_pkg::LC_RX_ON_BIT] = v.rx_on;
		r[ufcc_pkg::LC_WAKE_ADDR_BIT] = v.wake_by_addr;
		r[ufcc_pkg::LC_SYNC_MODE_BIT] = v.sync_mode;
		r[ufcc_pkg::LC_SMARTCARD_BIT] = v.smartcard;
		return r;
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************

	always_comb begin
		logic [31:0] lc_w;
		logic [31:0] fc_w;
		logic [2:0] ev_set;
		logic [2:0] ev_gate;
		next_s = s;
		// write data cut to the implemented bits, the rest reads back zero
		lc_w = wdata_in & ufcc_pkg::LC_WRITE_MASK;
		fc_w = wdata_in & ufcc_pkg::FC_WRITE_MASK;
		ev_set = 3'h0;
		ev_gate = 3'h0;

		// pin synchroniser
		next_s.rx_meta = rx_pin_in;
		next_s.rx_line = s.rx_meta;

		// software writes
		if (wr_in) begin
			unique case (addr_in)
				ufcc_pkg::OFS_LINE_CONTROL: begin
					next_s.break_send = lc_w[ufcc_pkg::LC_BREAK_SEND_BIT]; // RULE4
					next_s.mute = lc_w[ufcc_pkg::LC_MUTE_BIT]; // RULE2
					next_s.rx_on = lc_w[ufcc_pkg::LC_RX_ON_BIT];
					next_s.wake_by_addr = lc_w[ufcc_pkg::LC_WAKE_ADDR_BIT];
					next_s.sync_mode = lc_w[ufcc_pkg::LC_SYNC_MODE_BIT];
					next_s.smartcard = lc_w[ufcc_pkg::LC_SMARTCARD_BIT];
				end
				ufcc_pkg::OFS_FRAME_CLOCK: begin
					next_s.lin_mode = fc_w[ufcc_pkg::FC_LIN_BIT];
					next_s.stop_sel = fc_w[ufcc_pkg::FC_STOP_LSB +: 2];
					next_s.clock_pin = fc_w[ufcc_pkg::FC_CLOCK_PIN_BIT];
					next_s.idle_level = fc_w[ufcc_pkg::FC_IDLE_LEVEL_BIT];
					next_s.capture_edge = fc_w[ufcc_pkg::FC_CAPTURE_EDGE_BIT];
					next_s.last_pulse = fc_w[ufcc_pkg::FC_LAST_PULSE_BIT];
					next_s.break_irq = fc_w[ufcc_pkg::FC_BREAK_IRQ_BIT];
					next_s.break_len = fc_w[ufcc_pkg::FC_BREAK_LEN_BIT];
					next_s.node_addr = fc_w[ufcc_pkg::FC_NODE_ADDR_LSB +: 4]; // RULE16
				end
				ufcc_pkg::OFS_EVENT_STATUS: begin
					next_s.status = s.status & ~wdata_in[ufcc_pkg::EV_W-1:0];
				end
				ufcc_pkg::OFS_EVENT_MASK: begin
					next_s.mask = wdata_in[ufcc_pkg::EV_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// break completion clears the request; a new request in the same cycle wins
		// done is only honoured while a request is pending
		if (tx_break_done_in && s.break_send) begin // RULE17
			ev_set[ufcc_pkg::EV_BREAK_SENT_BIT] = 1'b1;
			if (!(wr_in && addr_in == ufcc_pkg::OFS_LINE_CONTROL
				&& lc_w[ufcc_pkg::LC_BREAK_SEND_BIT])) begin
				next_s.break_send = 1'b0; // RULE4
			end
		end

		// mute wake logic, only while the receiver runs
		if (s.rx_on) begin // RULE1
			// idle wake only acts while muted, so no wake event without a mute
			if (!s.wake_by_addr && rx_idle_in && s.mute) begin
				next_s.mute = 1'b0; // RULE2
				ev_set[ufcc_pkg::EV_WAKE_BIT] = 1'b1;
			end
			// a foreign address mutes again even right after a software unmute
			if (s.wake_by_addr && rx_addr_valid_in) begin
				if (rx_addr_in == s.node_addr) begin // RULE16
					next_s.mute = 1'b0; // RULE3
					ev_set[ufcc_pkg::EV_WAKE_BIT] = s.mute;
				end else begin
					next_s.mute = 1'b1; // RULE3
				end
			end
		end

		// break detection on the synchronised line in lin mode
		// detection disarms until the line is high, one event per low stretch
		next_s.break_det = 1'b0;
		if (s.rx_on && s.lin_mode && !s.rx_line) begin // RULE5
			if (s.armed) begin
				next_s.low_cnt = s.low_cnt + 16'h0001;
				if (s.low_cnt + 16'h0001 == break_cycles(s.break_len)) begin // RULE12
					next_s.break_det = 1'b1;
					next_s.armed = 1'b0;
					ev_set[ufcc_pkg::EV_BREAK_DET_BIT] = 1'b1;
				end
			end
		end else begin
			next_s.low_cnt = 16'h0000;
			next_s.armed = 1'b1;
		end

		// sticky events, a set beats a clear in the same cycle
		next_s.status = next_s.status | ev_set;

		// interrupt, the break detect event gated by its own enable
		// a new break enable counts in its own write cycle, no stale request
		ev_gate = 3'h7;
		ev_gate[ufcc_pkg::EV_BREAK_DET_BIT] = s.break_irq; // RULE11
		if (wr_in && addr_in == ufcc_pkg::OFS_FRAME_CLOCK) begin
			ev_gate[ufcc_pkg::EV_BREAK_DET_BIT] = fc_w[ufcc_pkg::FC_BREAK_IRQ_BIT];
		end
		next_s.irq = |(next_s.status & next_s.mask & ev_gate); // RULE11

		// derived line settings
		next_s.stop_halves = stop_halves(next_s.stop_sel); // RULE6
		next_s.sclk_oe = next_s.clock_pin
			&& (next_s.sync_mode || next_s.smartcard); // RULE7

		// register reads, data valid only in the following cycle
		next_s.rdata = 32'h00000000;
		if (rd_in) begin
			unique case (addr_in)
				ufcc_pkg::OFS_LINE_CONTROL: next_s.rdata = line_control_view(s);
				ufcc_pkg::OFS_FRAME_CLOCK: next_s.rdata = frame_clock_view(s); // RULE14
				ufcc_pkg::OFS_EVENT_STATUS: next_s.rdata = {29'h0, s.status};
				ufcc_pkg::OFS_EVENT_MASK: next_s.rdata = {29'h0, s.mask};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
			// synchroniser starts at the idle line level, no false low after reset
			s.rx_meta <= 1'b1;
			s.rx_line <= 1'b1;
			s.armed <= 1'b1;
			s.status <= ufcc_pkg::EV_RESET;
			s.stop_halves <= ufcc_pkg::HALVES_ONE;
		end else if (ce_in) begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// serial clock
	// ****************************************************************

	// clock runs only where the pin is driven
	assign sclk_active = s.sclk_oe; // RULE7

	// frozen together with the rest of the block while ce_in is low
	ufcc_sclk_gen #(
		.HALF_CYCLES(BIT_CYCLES / 2)
	) u_sclk (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.active_in(sclk_active),
		.idle_level_in(s.idle_level), // RULE8
		.capture_edge_in(s.capture_edge), // RULE9
		.last_pulse_in(s.last_pulse || s.smartcard), // RULE10
		.bit_start_in(tx_bit_start_in),
		.last_bit_in(tx_last_bit_in),
		.sclk_out(sclk_out),
		.capture_out(capture_out)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************

	// all straight from state flops
	// read data are zero outside the answer cycle
	assign rdata_out = s.rdata;
	assign rx_on_out = s.rx_on; // RULE1
	assign rx_mute_out = s.mute;
	assign tx_break_req_out = s.break_send; // RULE4
	assign lin_mode_out = s.lin_mode; // RULE5
	assign stop_halves_out = s.stop_halves;
	assign sclk_oe_out = s.sclk_oe;
	assign break_det_out = s.break_det;
	assign irq_out = s.irq;

endmodule // ufcc_top

// ---- verif/ufcc_top_sva.sv ----
`timescale 1ns/10ps
// ****************************************************************
// port checker for the frame and clock control block
// ****************************************************************
module ufcc_top_sva #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic rx_pin_in,
	input wire logic tx_break_done_in,
	input wire logic rx_on_out,
	input wire logic tx_break_req_out,
	input wire logic lin_mode_out,
	input wire logic [2:0] stop_halves_out,
	input wire logic sclk_oe_out,
	input wire logic capture_out,
	input wire logic break_det_out,
	input wire logic irq_out
);
	logic [15:0] low_run;
	logic line_prev;
	logic fc_rd;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	assign fc_rd = rd_in && addr_in == ufcc_pkg::OFS_FRAME_CLOCK;
	// length of the latest low stretch on the receive pin, held while high
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			low_run <= 16'h0000;
			line_prev <= 1'h1;
		end else begin
			line_prev <= rx_pin_in;
			if (!rx_pin_in) begin
				low_run <= line_prev ? 16'h0001 : low_run + 16'h0001;
			end
		end
	end
	chk_stop_map: assert property (fc_rd |=> stop_halves_out ==
		{rdata_out[13] & ~rdata_out[12], ~(rdata_out[13] ^ rdata_out[12]), rdata_out[12]})
		else $error("stop length output disagrees with register");
	chk_lin_view: assert property (fc_rd |=> lin_mode_out == rdata_out[14])
		else $error("lin mode output disagrees with register");
	chk_resv_zero: assert property (fc_rd |=> rdata_out[31:15] == 17'h00000 && !rdata_out[7])
		else $error("reserved bits read non zero");
	chk_break_hold: assert property (tx_break_req_out && !tx_break_done_in &&
		!(wr_in && addr_in == ufcc_pkg::OFS_LINE_CONTROL) |=> tx_break_req_out)
		else $error("break request dropped early");
	chk_break_clear: assert property (tx_break_req_out && tx_break_done_in && !wr_in
		|=> !tx_break_req_out)
		else $error("break request not cleared after done");
	chk_det_gate: assert property (break_det_out |-> rx_on_out && lin_mode_out)
		else $error("break seen with receiver or lin mode off");
	chk_det_length: assert property (break_det_out |-> low_run >= 16'(10 * BIT_CYCLES))
		else $error("break seen on a short low stretch");
	chk_capture_oe: assert property (capture_out |-> sclk_oe_out)
		else $error("capture pulse without clock drive");
	chk_oe_cause: assert property ($changed(sclk_oe_out) |-> $past(wr_in) || $past(wr_in, 2))
		else $error("clock drive changed without a write");
	// main scenarios reached
	cover property (break_det_out);
	cover property ($fell(tx_break_req_out));
	cover property (capture_out);
	cover property (irq_out);
endmodule // ufcc_top_sva

bind ufcc_top ufcc_top_sva #(.BIT_CYCLES(BIT_CYCLES)) chk (.clk_sys_in(clk_sys_in),
	.rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.rx_pin_in(rx_pin_in), .tx_break_done_in(tx_break_done_in), .rx_on_out(rx_on_out),
	.tx_break_req_out(tx_break_req_out), .lin_mode_out(lin_mode_out),
	.stop_halves_out(stop_halves_out), .sclk_oe_out(sclk_oe_out), .capture_out(capture_out),
	.break_det_out(break_det_out), .irq_out(irq_out));

// ---- verif/ufcc_line_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// serial line partner: receive line and transmitter break answer
// ****************************************************************
module ufcc_line_model #(
	parameter int DONE_DELAY = 6
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic break_req_in,
	output logic rx_pin_out,
	output logic tx_break_done_out
);
	int wait_cnt;
	// idle line is high
	initial begin
		rx_pin_out = 1'h1;
		tx_break_done_out = 1'h0;
		wait_cnt = 0;
	end
	// reports the break frame finished some cycles after the request
	always @(posedge clk_sys_in) begin
		tx_break_done_out <= !rst_in && break_req_in && wait_cnt == DONE_DELAY;
		if (rst_in || !break_req_in || wait_cnt == DONE_DELAY) begin
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	// pulls the line low for n cycles, then releases it high
	task automatic hold_low(input int n);
		@(posedge clk_sys_in);
		rx_pin_out <= 1'h0;
		repeat (n) @(posedge clk_sys_in);
		rx_pin_out <= 1'h1;
	endtask
endmodule // ufcc_line_model

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
// ****************************************************************
// self checking bench
// ****************************************************************
module testbench;
	localparam int BC = 4;
	logic clk_sys_in, rst_in, wr, rd, idle, av, bs, lb, brk_req, brk_done, rx_pin, prev;
	logic rx_on, mute, lin, sclk, oe, cap, det, irq;
	logic [7:0] addr;
	logic [3:0] raddr;
	logic [2:0] halves;
	logic [31:0] wdata, rdata, v, r;
	int num_errors = 0;
	int n_checks = 0;
	int dets = 0;
	int tg, ci, ti, n;
	ufcc_top #(.BIT_CYCLES(BC)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'h1),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.rx_pin_in(rx_pin), .rx_idle_in(idle), .rx_addr_valid_in(av), .rx_addr_in(raddr),
		.tx_bit_start_in(bs), .tx_last_bit_in(lb), .tx_break_done_in(brk_done),
		.rx_on_out(rx_on), .rx_mute_out(mute), .tx_break_req_out(brk_req), .lin_mode_out(lin),
		.stop_halves_out(halves), .sclk_out(sclk), .sclk_oe_out(oe), .capture_out(cap),
		.break_det_out(det), .irq_out(irq));
	ufcc_line_model line (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .break_req_in(brk_req),
		.rx_pin_out(rx_pin), .tx_break_done_out(brk_done));
	// clock and break counter
	initial begin
		clk_sys_in = 1'h0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		if (det === 1'h1) dets++;
	end
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [2:0] halves_of(input logic [1:0] c);
		case (c)
			2'h0: return 3'h2;
			2'h1: return 3'h1;
			2'h2: return 3'h4;
			default: return 3'h3;
		endcase
	endfunction
	// register bus cycles
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk_sys_in);
		wr <= 1'h0;
		#1; // let the write settle before the caller looks
	endtask
	task automatic br(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk_sys_in);
		rd <= 1'h0;
		#1 d = rdata;
	endtask
	// one receiver event pulse, idle line or address character
	task automatic rx_ev(input logic is_idle, input logic [3:0] a);
		@(posedge clk_sys_in);
		idle <= is_idle;
		av <= !is_idle;
		raddr <= a;
		@(posedge clk_sys_in);
		idle <= 1'h0;
		av <= 1'h0;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask
	// one synchronous data bit, counting clock toggles and capture position
	task automatic sbit(input logic last);
		@(posedge clk_sys_in);
		bs <= 1'h1;
		lb <= last;
		prev = sclk;
		tg = 0;
		ci = -1;
		ti = 99;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk_sys_in);
			bs <= 1'h0;
			lb <= 1'h0;
			#1;
			if (sclk !== prev) begin
				tg++;
				if (tg == 2) ti = k;
			end
			if (cap === 1'h1) ci = k;
			prev = sclk;
		end
	endtask
	task automatic low_wait(input int len);
		line.hold_low(len);
		repeat (5) @(posedge clk_sys_in);
		#1;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		num_errors++;
		final_report();
	end
	initial begin
		{wr, rd, idle, av, bs, lb} = 6'h00;
		addr = 8'h00;
		raddr = 4'h0;
		wdata = 32'h00000000;
		rst_in = 1'h1;
		void'($urandom(57206));
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		br(ufcc_pkg::OFS_FRAME_CLOCK, r);
		check("fc reset", r, 32'h00000000);
		check("halves reset", 32'(halves), 32'h00000002);
		br(8'h10, r);
		check("unmapped", r, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			v = ($urandom() & 32'hFFFFCF7F) | (32'(i % 4) << 12);
			bw(ufcc_pkg::OFS_FRAME_CLOCK, v);
			br(ufcc_pkg::OFS_FRAME_CLOCK, r);
			check("fc read", r, v & ufcc_pkg::FC_WRITE_MASK);
			check("halves", 32'(halves), 32'(halves_of(v[13:12])));
			check("lin", 32'(lin), 32'(v[14]));
		end
		bw(ufcc_pkg::OFS_FRAME_CLOCK, 32'h00000005);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000006);
		check("rx on", 32'(rx_on), 32'h00000001);
		check("mute set", 32'(mute), 32'h00000001);
		rx_ev(1'h1, 4'h0);
		check("idle wake", 32'(mute), 32'h00000000);
		br(ufcc_pkg::OFS_EVENT_STATUS, r);
		check("wake flag", 32'(r[1]), 32'h00000001);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000002);
		rx_ev(1'h1, 4'h0);
		check("rx off mute", 32'(mute), 32'h00000001);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h0000000E);
		rx_ev(1'h0, 4'h3);
		check("mismatch", 32'(mute), 32'h00000001);
		rx_ev(1'h1, 4'h0);
		check("idle in addr", 32'(mute), 32'h00000001);
		rx_ev(1'h0, 4'h5);
		check("match", 32'(mute), 32'h00000000);
		rx_ev(1'h0, 4'h9);
		check("remute", 32'(mute), 32'h00000001);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000001);
		repeat (3) @(posedge clk_sys_in);
		#1 check("break held", 32'(brk_req), 32'h00000001);
		for (n = 0; n < 20 && brk_req !== 1'h0; n++) @(posedge clk_sys_in);
		#1 check("break clear", 32'(brk_req), 32'h00000000);
		br(ufcc_pkg::OFS_EVENT_STATUS, r);
		check("break sent", 32'(r[2]), 32'h00000001);
		bw(ufcc_pkg::OFS_EVENT_STATUS, 32'h00000007);
		br(ufcc_pkg::OFS_EVENT_STATUS, r);
		check("status clear", r, 32'h00000000);
		bw(ufcc_pkg::OFS_EVENT_MASK, 32'h00000001);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000004);
		bw(ufcc_pkg::OFS_FRAME_CLOCK, 32'h00004060);
		low_wait(11 * BC - 3);
		check("short break", 32'(dets), 32'h00000000);
		low_wait(11 * BC + 3);
		check("long break", 32'(dets), 32'h00000001);
		check("irq on", 32'(irq), 32'h00000001);
		bw(ufcc_pkg::OFS_FRAME_CLOCK, 32'h00004020);
		@(posedge clk_sys_in);
		#1 check("irq off", 32'(irq), 32'h00000000);
		bw(ufcc_pkg::OFS_FRAME_CLOCK, 32'h00004000);
		low_wait(10 * BC - 3);
		low_wait(10 * BC + 3);
		check("ten bit", 32'(dets), 32'h00000002);
		bw(ufcc_pkg::OFS_FRAME_CLOCK, 32'h00000000);
		low_wait(12 * BC);
		check("lin off", 32'(dets), 32'h00000002);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000010);
		for (int p = 0; p < 4; p++) begin
			v = 32'h00000800 | (32'(p) << 9);
			bw(ufcc_pkg::OFS_FRAME_CLOCK, v | 32'h00000100);
			repeat (3) @(posedge clk_sys_in);
			#1 check("oe", 32'(oe), 32'h00000001);
			check("idle level", 32'(sclk), 32'(v[10]));
			sbit(1'h0);
			check("toggles", tg, 2);
			check("phase", 32'(ci >= ti), 32'(v[9]));
			bw(ufcc_pkg::OFS_FRAME_CLOCK, v);
			sbit(1'h1);
			check("no last pulse", tg, 0);
		end
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000020);
		bw(ufcc_pkg::OFS_FRAME_CLOCK, 32'h00000800);
		repeat (3) @(posedge clk_sys_in);
		#1 check("oe smartcard", 32'(oe), 32'h00000001);
		sbit(1'h1);
		check("smartcard last", tg, 2);
		bw(ufcc_pkg::OFS_LINE_CONTROL, 32'h00000000);
		repeat (3) @(posedge clk_sys_in);
		#1 check("oe async", 32'(oe), 32'h00000000);
		final_report();
	end
endmodule // testbench
